// File: nibble_exec.sv
/*
 * Execution block of a 4-bit core for rotate right through carry,
 * subroutine return and the four subtract-with-borrow forms, with a
 * 128-nibble data RAM, accumulator, flags, program counter and an
 * eight-deep return stack, all reached over Avalon-MM.
 * Assumes a well-behaved master that holds its request while
 * waitrequest is high.
 */
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module nibble_exec #(
  parameter int RAM_DEPTH = 128
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [nibble_core_pkg::BUS_AW-1:0] avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest
);
  import nibble_core_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [3:0]        work_sum_reg_q, work_sum_reg_d;
  logic              carry_flag_q, carry_flag_d;
  logic              zero_flag_q, zero_flag_d;
  logic [PC_W-1:0]   program_counter_q, program_counter_d;
  logic [SP_W-1:0]   sp_q, sp_d;
  logic [RAM_AW-1:0] raddr_q, raddr_d;
  logic [2:0]        status_q, status_d;
  logic              ack_q, ack_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [3:0]        ram_q [RAM_DEPTH];
  logic [PC_W-1:0]   stack_q [STACK_N];

  // RAM and stack write ports
  logic              ram_we;
  logic [RAM_AW-1:0] ram_wa;
  logic [3:0]        ram_wd;
  logic              push_we;

  // Decode and datapath
  logic              wr_go;
  logic [15:0]       insn;
  logic              rotate_right_carry_op, subroutine_return_op;
  logic              sub_borrow_to_acc_op, sub_borrow_writeback_op;
  logic              sub_mem, sub_mem_wb, sub_imm, sub_imm_wb;
  logic              use_imm, known_op;
  logic [RAM_AW-1:0] opnd_addr;
  logic [3:0]        opa, opb, alu_res;
  logic              alu_cout, alu_zero;
  alu_mode_t         alu_mode;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle gives a registered read word before the accept edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_go           = avs_write & ack_q;
  assign avs_readdata    = rdata_q;
  assign insn            = avs_writedata[INSN_W-1:0];

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  always_comb begin
    rotate_right_carry_op =
      (insn[15:MEM_PREFIX_LSB] == OP_ROT_RIGHT);
    subroutine_return_op  = (insn == OP_RETURN);
    sub_mem    = (insn[15:MEM_PREFIX_LSB] == OP_SUB_MEM);
    sub_mem_wb = (insn[15:MEM_PREFIX_LSB] == OP_SUBW_MEM);
    sub_imm    = (insn[15:IMM_PREFIX_LSB] == OP_SUB_IMM);
    sub_imm_wb = (insn[15:IMM_PREFIX_LSB] == OP_SUBW_IMM);
    sub_borrow_to_acc_op    = sub_mem | sub_imm;
    sub_borrow_writeback_op = sub_mem_wb | sub_imm_wb;
    use_imm  = sub_imm | sub_imm_wb;
    known_op = rotate_right_carry_op | subroutine_return_op
             | sub_borrow_to_acc_op | sub_borrow_writeback_op;
    // Working registers are the lowest sixteen RAM nibbles
    opnd_addr = use_imm ? {3'h0, insn[3:0]}
                        : insn[RAM_AW-1:0];
  end

  // ---------------------------------------------------------------
  // Operand select
  // ---------------------------------------------------------------
  always_comb begin
    opa = ram_q[opnd_addr];
    opb = use_imm ? insn[IMM_LSB+3:IMM_LSB]
                  : work_sum_reg_q;
    alu_mode = rotate_right_carry_op ? ALU_ROT : ALU_SUB;
  end

  nibble_alu u_alu (
    .mode (alu_mode),
    .opa  (opa),
    .opb  (opb),
    .cin  (carry_flag_q),
    .res  (alu_res),
    .cout (alu_cout),
    .zero (alu_zero)
  );

  // ---------------------------------------------------------------
  // Next state: execution and register writes
  // ---------------------------------------------------------------
  always_comb begin
    work_sum_reg_d    = work_sum_reg_q;
    carry_flag_d      = carry_flag_q;
    zero_flag_d       = zero_flag_q;
    program_counter_d = program_counter_q;
    sp_d              = sp_q;
    raddr_d           = raddr_q;
    status_d          = status_q;
    ram_we            = 1'b0;
    ram_wa            = raddr_q;
    ram_wd            = avs_writedata[3:0];
    push_we           = 1'b0;
    ack_d             = (avs_read | avs_write) & ~ack_q;
    if (wr_go) begin
      case (avs_address)
        OFS_INSN: begin
          if (known_op && !subroutine_return_op) begin
            // Whole instruction retires in the accept cycle
            work_sum_reg_d    = alu_res;
            carry_flag_d      = alu_cout;
            zero_flag_d       = alu_zero;
            program_counter_d = program_counter_q + 11'h001;
            ram_wa = opnd_addr;
            ram_wd = alu_res;
            ram_we = rotate_right_carry_op
                   | sub_borrow_writeback_op;
          end else if (subroutine_return_op) begin
            if (sp_q != 4'h0) begin
              program_counter_d =
                stack_q[3'(sp_q - 4'h1)];
              sp_d = sp_q - 4'h1;
            end else begin
              status_d[ST_UNDER_BIT] = 1'b1;
            end
          end else begin
            status_d[ST_ILLEGAL_BIT] = 1'b1;
          end
        end
        OFS_ACC:   work_sum_reg_d = avs_writedata[3:0];
        OFS_FLAGS: begin
          carry_flag_d = avs_writedata[FLAG_CARRY_BIT];
          zero_flag_d  = avs_writedata[FLAG_ZERO_BIT];
        end
        OFS_PC:    program_counter_d = avs_writedata[PC_W-1:0];
        OFS_STACK: begin
          // Full stack refuses the push rather than overwrite
          if (sp_q < 4'(STACK_N)) begin
            push_we = 1'b1;
            sp_d    = sp_q + 4'h1;
          end else begin
            status_d[ST_OVER_BIT] = 1'b1;
          end
        end
        OFS_RADDR: raddr_d = avs_writedata[RAM_AW-1:0];
        OFS_RDATA: ram_we  = 1'b1;
        // Write one to clear; no status event can share this cycle,
        // since every event comes from a write to another offset
        OFS_STATUS: status_d = status_q & ~avs_writedata[2:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read word, prepared during the wait cycle
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (avs_read & ~ack_q) begin
      case (avs_address)
        OFS_ACC:    rdata_d = {28'h0, work_sum_reg_q};
        OFS_FLAGS:  rdata_d = {30'h0, zero_flag_q, carry_flag_q};
        OFS_PC:     rdata_d = {21'h0, program_counter_q};
        OFS_STACK:  rdata_d = {28'h0, sp_q};
        OFS_RADDR:  rdata_d = {25'h0, raddr_q};
        OFS_RDATA:  rdata_d = {28'h0, ram_q[raddr_q]};
        OFS_STATUS: rdata_d = {29'h0, status_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      work_sum_reg_q    <= RST_ACC;
      carry_flag_q      <= 1'b0;
      zero_flag_q       <= 1'b0;
      program_counter_q <= RST_PC;
      sp_q              <= 4'h0;
      raddr_q           <= RST_RADDR;
      status_q          <= 3'h0;
      ack_q             <= 1'b0;
      rdata_q           <= 32'h0000_0000;
    end else begin
      work_sum_reg_q    <= work_sum_reg_d;
      carry_flag_q      <= carry_flag_d;
      zero_flag_q       <= zero_flag_d;
      program_counter_q <= program_counter_d;
      sp_q              <= sp_d;
      raddr_q           <= raddr_d;
      status_q          <= status_d;
      ack_q             <= ack_d;
      rdata_q           <= rdata_d;
    end
  end

  // Storage arrays carry data only, so they have no reset
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
    if (push_we) begin
      stack_q[sp_q[2:0]] <= avs_writedata[PC_W-1:0];
    end
  end

endmodule : nibble_exec

// File: nibble_core_pkg.sv
/*
 * Constants shared by the nibble execution block: register offsets,
 * field layouts, opcode prefixes, reset values and storage sizes.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package nibble_core_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int NIB_W      = 4;
  localparam int INSN_W     = 16;
  localparam int RAM_AW     = 7;
  localparam int PC_W       = 11;
  localparam int STACK_N    = 8;
  localparam int SP_W       = 4;
  localparam int BUS_AW     = 6;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_INSN   = 6'h00;
  localparam logic [5:0] OFS_ACC    = 6'h04;
  localparam logic [5:0] OFS_FLAGS  = 6'h08;
  localparam logic [5:0] OFS_PC     = 6'h0c;
  localparam logic [5:0] OFS_STACK  = 6'h10;
  localparam logic [5:0] OFS_RADDR  = 6'h14;
  localparam logic [5:0] OFS_RDATA  = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_ZERO_BIT  = 1;
  localparam int ST_ILLEGAL_BIT = 0;
  localparam int ST_UNDER_BIT   = 1;
  localparam int ST_OVER_BIT    = 2;
  localparam int MEM_PREFIX_LSB = 7;
  localparam int IMM_PREFIX_LSB = 8;
  localparam int IMM_LSB        = 4;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [8:0]  OP_ROT_RIGHT = 9'h09b;  // 0 1001 1011
  localparam logic [15:0] OP_RETURN    = 16'h0080;
  localparam logic [8:0]  OP_SUB_MEM   = 9'h014;  // 0 0001 0100
  localparam logic [8:0]  OP_SUBW_MEM  = 9'h016;  // 0 0001 0110
  localparam logic [7:0]  OP_SUB_IMM   = 8'h0e;
  localparam logic [7:0]  OP_SUBW_IMM  = 8'h0f;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  RST_ACC    = 4'h0;
  localparam logic [10:0] RST_PC     = 11'h000;
  localparam logic [6:0]  RST_RADDR  = 7'h00;

  typedef enum logic [1:0] {
    ALU_ROT = 2'b00,
    ALU_SUB = 2'b01
  } alu_mode_t;

endpackage : nibble_core_pkg

// File: nibble_alu.sv
/*
 * Four-bit arithmetic slice: rotate right through carry, or
 * subtract with borrow. Purely combinational; the caller registers.
 */
`timescale 1ns/1ps
module nibble_alu (
  input  wire nibble_core_pkg::alu_mode_t mode,
  input  wire logic [3:0]                 opa,
  input  wire logic [3:0]                 opb,
  input  wire logic                       cin,
  output logic      [3:0]                 res,
  output logic                            cout,
  output logic                            zero
);
  import nibble_core_pkg::*;

  logic [4:0] diff;

  // ---------------------------------------------------------------
  // Result and flags
  // ---------------------------------------------------------------
  // Extra top bit of the difference is the borrow out
  always_comb begin
    diff = 5'h00;
    res  = 4'h0;
    cout = 1'b0;
    case (mode)
      ALU_ROT: begin
        res  = {cin, opa[3:1]};
        cout = opa[0];
      end
      ALU_SUB: begin
        diff = {1'b0, opa} - {1'b0, opb} - {4'h0, cin};
        res  = diff[3:0];
        cout = diff[4];
      end
      default: begin
        res  = 4'h0;
        cout = 1'b0;
      end
    endcase
    zero = (res == 4'h0);
  end

endmodule : nibble_alu

// File: nibble_exec_sva.sv
/* Bus-level assertions for nibble_exec.
   Assumes a master that holds each request until it is accepted. */
`timescale 1ns/1ps
module nibble_exec_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  import nibble_core_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Handshake steps
  // ---------------------------------------------------------------
  logic req;
  logic take_rd;
  assign req     = avs_read || avs_write;
  assign take_rd = avs_read && !avs_waitrequest;
  sequence s_wait; req && avs_waitrequest; endsequence
  sequence s_held; req; endsequence
  // Every instruction costs exactly one wait cycle
  a_one_wait: assert property (
    s_wait ##1 s_held |-> !avs_waitrequest)
    else $error("request waited more than one cycle");
  a_first_wait: assert property ($rose(req) |-> avs_waitrequest)
    else $error("request accepted without a wait cycle");
  a_idle_quiet: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_rdata_idle: assert property (!take_rd |-> avs_readdata == 32'h0)
    else $error("read data outside the accept cycle");
  // Upper bits stay clear: values wrap at their field widths, stack depth stops at eight
  a_acc_width: assert property (
    take_rd && avs_address == OFS_ACC |-> avs_readdata[31:4] == 28'h0)
    else $error("accumulator wider than a nibble");
  a_pc_width: assert property (
    take_rd && avs_address == OFS_PC |-> avs_readdata[31:11] == 21'h0)
    else $error("program counter wider than eleven bits");
  a_flag_width: assert property (
    take_rd && avs_address == OFS_FLAGS |-> avs_readdata[31:2] == 30'h0)
    else $error("flags wider than two bits");
  a_ram_width: assert property (
    take_rd && avs_address == OFS_RDATA |-> avs_readdata[31:4] == 28'h0)
    else $error("RAM word wider than a nibble");
  a_unmapped_zero: assert property (take_rd && avs_address >= 6'h20
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_depth_max: assert property (
    take_rd && avs_address == OFS_STACK |-> avs_readdata <= STACK_N)
    else $error("stack depth beyond eight");
endmodule : nibble_exec_sva

bind nibble_exec nibble_exec_sva u_sva (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest)
);

// File: tb_nibble_exec.sv
/* Self-checking bench for nibble_exec, driven over Avalon-MM.
   Assumes the shared package and the bound checker. */
`timescale 1ns/1ps
module tb_nibble_exec;
  import nibble_core_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          errors = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  nibble_exec dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );
  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  // ---------------------------------------------------------------
  // Bus access: request held until waitrequest is low at a rising edge
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Read right after the edge: these are the values the slave sampled
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    if (n >= 16) begin
      errors++;
      $display("CHECK FAILED t=%0t no answer from slave", $time);
      tally_and_finish();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge, so the next call never re-raises in this step
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd
  // One instruction: k 0 rotate, 1/2 memory, 3/4 immediate subtract
  task automatic op_case(input int k, input logic [3:0] m,
                         input logic [3:0] b, input logic c);
    logic [15:0] insn;
    logic [4:0]  dif;
    logic [3:0]  res;
    logic        co;
    logic [6:0]  loc;
    loc = (k >= 3) ? 7'h0b : 7'h7f;
    dif = {1'b0, m} - {1'b0, b} - {4'h0, c};
    res = (k == 0) ? {c, m[3:1]} : dif[3:0];
    co = (k == 0) ? m[0] : dif[4];
    case (k)
      0: insn = {OP_ROT_RIGHT, loc};
      1: insn = {OP_SUB_MEM, loc};
      2: insn = {OP_SUBW_MEM, loc};
      3: insn = {OP_SUB_IMM, b, loc[3:0]};
      default: insn = {OP_SUBW_IMM, b, loc[3:0]};
    endcase
    wr(OFS_RADDR, {25'h0, loc});
    wr(OFS_RDATA, {28'h0, m});
    // Immediate forms get a decoy accumulator to catch a wrong operand
    wr(OFS_ACC, {28'h0, (k >= 3) ? ~b : b});
    wr(OFS_FLAGS, {30'h0, 1'b1, c});
    wr(OFS_PC, 32'h100 + k);
    wr(OFS_INSN, {16'h0, insn});
    rd(OFS_ACC, {28'h0, res});
    rd(OFS_FLAGS, {30'h0, res == 4'h0, co});
    rd(OFS_RDATA, {28'h0, (k == 1 || k == 3) ? m : res});
    rd(OFS_PC, 32'h101 + k);
  endtask : op_case
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values and quiet places
    rd(OFS_ACC, {28'h0, RST_ACC});
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_PC, {21'h0, RST_PC});
    rd(OFS_STACK, 32'h0);
    rd(OFS_RADDR, {25'h0, RST_RADDR});
    rd(OFS_STATUS, 32'h0);
    rd(OFS_INSN, 32'h0);
    rd(6'h20, 32'h0);
    // Each operation over borrow, zero and wrap corners
    for (int k = 0; k < 5; k++) begin
      op_case(k, 4'h1, 4'h0, 1'b0);
      op_case(k, 4'ha, 4'h3, 1'b1);
      op_case(k, 4'h5, 4'h5, 1'b0);
      op_case(k, 4'h3, 4'h4, 1'b1);
      op_case(k, 4'h0, 4'hf, 1'b1);
    end
    // Last case used working register eleven as the RAM address
    rd(OFS_RADDR, 32'h0b);
    // Return pops in reverse push order, then underflows
    wr(OFS_PC, 32'h055);
    wr(OFS_STACK, 32'h7ff);
    wr(OFS_STACK, 32'h123);
    rd(OFS_STACK, 32'h2);
    wr(OFS_INSN, {16'h0, OP_RETURN});
    rd(OFS_PC, 32'h123);
    rd(OFS_STACK, 32'h1);
    wr(OFS_INSN, {16'h0, OP_RETURN});
    rd(OFS_PC, 32'h7ff);
    wr(OFS_INSN, {16'h0, OP_RETURN});
    rd(OFS_PC, 32'h7ff);
    rd(OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h0);
    // Ninth push is refused and flagged; the eighth stays on top
    for (int i = 0; i < 9; i++) begin
      wr(OFS_STACK, 32'h200 + i);
    end
    rd(OFS_STACK, 32'h8);
    rd(OFS_STATUS, 32'h4);
    wr(OFS_INSN, {16'h0, OP_RETURN});
    rd(OFS_PC, 32'h207);
    wr(OFS_STATUS, 32'h4);
    // Unknown opcode flags itself and touches nothing else
    wr(OFS_INSN, 32'hffff);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_PC, 32'h207);
    tally_and_finish();
  end
endmodule : tb_nibble_exec
